// File: rpmq_consts.svh
// Register offsets, field positions, window mask and queue depths of the root port queue block
`ifndef RPMQ_CONSTS_SVH
`define RPMQ_CONSTS_SVH
`define RPMQ_OFF_STATUS 12'h148
`define RPMQ_OFF_MSI_UP 12'h14C
`define RPMQ_OFF_MSI_LO 12'h150
`define RPMQ_OFF_ERRQ 12'h154
`define RPMQ_OFF_INTQ1 12'h158
`define RPMQ_OFF_INTQ2 12'h15C
`define RPMQ_BIT_GATE 0
`define RPMQ_BIT_ERR_NE 16
`define RPMQ_BIT_ERR_OV 17
`define RPMQ_BIT_INT_NE 18
`define RPMQ_BIT_INT_OV 19
`define RPMQ_MSI_LO_MASK 32'hFFFFF000
`define RPMQ_ZERO32 32'h00000000
`define RPMQ_ERR_DEPTH 4
`define RPMQ_INT_DEPTH 8
`endif

// File: rpmq_pkg.sv
// Types shared by the root port queue block
package rpmq_pkg;
  typedef struct packed {
    logic [1:0] severity;
    logic [15:0] req_id;
  } rpmq_err_msg_t;

  typedef struct packed {
    logic is_msg_signalled;
    logic assert_flag;
    logic [1:0] int_line;
    logic [10:0] msi_addr;
    logic [15:0] req_id;
    logic [15:0] payload;
  } rpmq_int_msg_t;

  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } rpmq_bus_req_t;

  typedef struct packed {
    logic [63:0] addr;
    logic [15:0] req_id;
    logic [15:0] data;
  } rpmq_memwr_t;
endpackage

// File: rpmq_queue.sv
// Small synchronous queue with peek at the head and drop-on-full push
`timescale 1ns/10ps
module rpmq_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Push side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  // Pop side
  input wire logic pop,
  output logic [WIDTH-1:0] head,
  output logic not_empty,
  output logic full
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
  } rpmq_q_state_t;

  logic [WIDTH-1:0] mem [DEPTH];
  rpmq_q_state_t st_reg;
  rpmq_q_state_t st_next;
  logic do_push;
  logic do_pop;

  assign full = (st_reg.count == (AW+1)'(DEPTH));
  assign not_empty = (st_reg.count != '0);
  assign head = mem[st_reg.rptr];
  assign do_pop = pop && not_empty;
  assign do_push = push && (!full || do_pop);

  function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p);
    inc_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_comb begin
    st_next = st_reg;
    if (do_push) begin
      st_next.wptr = inc_ptr(st_reg.wptr);
    end
    if (do_pop) begin
      st_next.rptr = inc_ptr(st_reg.rptr);
    end
    if (do_push && !do_pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (do_pop && !do_push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[st_reg.wptr] <= push_data;
    end
  end
endmodule // rpmq_queue

// File: rpmq_regs.sv
// Root port status/control, MSI window and message queue registers
//
// Summary of operation
// - Outbound window accesses pass to the link only while gate bit 0 is set.
// - Gate bit clears itself when the link falls from up to down.
// - Non-root-port build reads status/control as zero and ignores writes.
// - Status bit 16 is high while the error queue holds an entry.
// - Error message into full queue is dropped and sets sticky bit 17, write-1-clear.
// - Status bit 18 is high while the interrupt queue holds an entry.
// - Interrupt message into full queue is dropped, sets sticky bit 19, write-1-clear.
// - Upper Msi_window_base register holds upper 32 address bits, fully read-write.
// - Memory write inside programmed 4 KB window is an MSI; bits 11:0 read zero.
// - Endpoint build reads both Msi_window_base registers as zero.
// - No MSI-X decoding; only writes to the window count as MSI.
// - Error queue read peeks the head; any write there pops it.
// - Error entry holds requester id in 15:0 and severity in 17:16.
// - Error read bit 18 shows whether a valid entry was returned.
// - Interrupt register reads do not pop; a write to either one pops.
// - Non-root-port build reads the first interrupt register as zero.
// - Interrupt entry holds requester id 15:0 and MSI address bits 12:2 in 26:16.
// - Bits 28:27 give legacy line A to D; zero for MSI.
// - Bit 29 is one for legacy assert, zero for deassert and MSI.
// - Bit 30 marks MSI; bit 31 shows a valid entry was returned.
// - Second interrupt register gives MSI payload in 15:0; zero for legacy.
`timescale 1ns/10ps
`include "rpmq_consts.svh"
module rpmq_regs import rpmq_pkg::*; #(
  parameter bit ROOT_PORT = 1'b1,
  parameter int ERR_DEPTH = `RPMQ_ERR_DEPTH,
  parameter int INT_DEPTH = `RPMQ_INT_DEPTH
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Link state
  input wire logic link_up,
  // Outbound window request and forwarded request
  input wire logic outbound_window_req,
  output logic outbound_window_fwd,
  // Inbound memory write
  input wire logic memwr_valid,
  input wire rpmq_memwr_t memwr,
  // Received error message
  input wire logic err_msg_valid,
  input wire rpmq_err_msg_t err_msg,
  // Received legacy interrupt message
  input wire logic intx_msg_valid,
  input wire logic [15:0] intx_req_id,
  input wire logic [1:0] intx_line,
  input wire logic intx_assert
);
  ////////////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    logic gate;
    logic err_ov;
    logic int_ov;
    logic link_up_d;
    logic [31:0] msi_up;
    logic [19:0] msi_lo;
    logic [31:0] rdata;
    logic fwd;
  } rpmq_state_t;

  rpmq_state_t st_reg;
  rpmq_state_t st_next;

  rpmq_err_msg_t err_head;
  rpmq_int_msg_t int_head;
  rpmq_int_msg_t int_push_data;
  logic err_ne;
  logic err_full;
  logic int_ne;
  logic int_full;
  logic err_pop;
  logic int_pop;
  logic msi_hit;
  logic int_push;
  logic wr_status;

  function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
    addr_is = (a == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // MSI window decode and queue feeds
  assign msi_hit = ROOT_PORT && memwr_valid
    && (memwr.addr[63:32] == st_reg.msi_up)
    && (memwr.addr[31:12] == st_reg.msi_lo);
  assign int_push = msi_hit || (ROOT_PORT && intx_msg_valid);

  always_comb begin
    int_push_data = '0;
    if (msi_hit) begin
      int_push_data.is_msg_signalled = 1'b1;
      int_push_data.msi_addr = memwr.addr[12:2];
      int_push_data.req_id = memwr.req_id;
      int_push_data.payload = memwr.data;
    end else begin
      int_push_data.req_id = intx_req_id;
      int_push_data.int_line = intx_line;
      int_push_data.assert_flag = intx_assert;
    end
  end

  assign err_pop = ROOT_PORT && reg_wr && addr_is(reg_addr, `RPMQ_OFF_ERRQ);
  assign int_pop = ROOT_PORT && reg_wr
    && (addr_is(reg_addr, `RPMQ_OFF_INTQ1) || addr_is(reg_addr, `RPMQ_OFF_INTQ2));
  assign wr_status = ROOT_PORT && reg_wr && addr_is(reg_addr, `RPMQ_OFF_STATUS);

  ////////////////////////////////////////////////////////////////////////////////
  // Queues; a pop on an empty queue is ignored inside the queue
  rpmq_queue #(
    .WIDTH($bits(rpmq_err_msg_t)),
    .DEPTH(ERR_DEPTH)
  ) u_err_q (
    .mclk(mclk),
    .rst_b(rst_b),
    .push(ROOT_PORT && err_msg_valid),
    .push_data(err_msg),
    .pop(err_pop),
    .head(err_head),
    .not_empty(err_ne),
    .full(err_full)
  );

  rpmq_queue #(
    .WIDTH($bits(rpmq_int_msg_t)),
    .DEPTH(INT_DEPTH)
  ) u_int_q (
    .mclk(mclk),
    .rst_b(rst_b),
    .push(int_push),
    .push_data(int_push_data),
    .pop(int_pop),
    .head(int_head),
    .not_empty(int_ne),
    .full(int_full)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_next = st_reg;
    st_next.link_up_d = link_up;
    st_next.rdata = `RPMQ_ZERO32;
    // Status/control writes
    if (wr_status) begin
      st_next.gate = reg_wdata[`RPMQ_BIT_GATE];
      if (reg_wdata[`RPMQ_BIT_ERR_OV]) begin
        st_next.err_ov = 1'b0;
      end
      if (reg_wdata[`RPMQ_BIT_INT_OV]) begin
        st_next.int_ov = 1'b0;
      end
    end
    if (st_reg.link_up_d && !link_up) begin
      st_next.gate = 1'b0;
    end
    // Overflow sets win over clears; a pop in the same cycle frees a slot
    if (ROOT_PORT && err_msg_valid && err_full && !err_pop) begin
      st_next.err_ov = 1'b1;
    end
    if (int_push && int_full && !int_pop) begin
      st_next.int_ov = 1'b1;
    end
    // MSI window registers
    if (ROOT_PORT && reg_wr && addr_is(reg_addr, `RPMQ_OFF_MSI_UP)) begin
      st_next.msi_up = reg_wdata;
    end
    if (ROOT_PORT && reg_wr && addr_is(reg_addr, `RPMQ_OFF_MSI_LO)) begin
      st_next.msi_lo = reg_wdata[31:12];
    end
    // Read data, registered one cycle after the strobe
    if (reg_rd && ROOT_PORT) begin
      case (reg_addr)
        `RPMQ_OFF_STATUS: begin
          st_next.rdata[`RPMQ_BIT_GATE] = st_reg.gate;
          st_next.rdata[`RPMQ_BIT_ERR_NE] = err_ne;
          st_next.rdata[`RPMQ_BIT_ERR_OV] = st_reg.err_ov;
          st_next.rdata[`RPMQ_BIT_INT_NE] = int_ne;
          st_next.rdata[`RPMQ_BIT_INT_OV] = st_reg.int_ov;
        end
        `RPMQ_OFF_MSI_UP: begin
          st_next.rdata = st_reg.msi_up;
        end
        `RPMQ_OFF_MSI_LO: begin
          st_next.rdata = {st_reg.msi_lo, 12'h000} & `RPMQ_MSI_LO_MASK;
        end
        `RPMQ_OFF_ERRQ: begin
          if (err_ne) begin
            st_next.rdata = {13'h0000, 1'b1, err_head.severity, err_head.req_id};
          end
        end
        `RPMQ_OFF_INTQ1: begin
          if (int_ne) begin
            st_next.rdata = {1'b1, int_head.is_msg_signalled, int_head.assert_flag,
              int_head.int_line, int_head.msi_addr, int_head.req_id};
          end
        end
        `RPMQ_OFF_INTQ2: begin
          if (int_ne && int_head.is_msg_signalled) begin
            st_next.rdata = {16'h0000, int_head.payload};
          end
        end
        default: begin
          st_next.rdata = `RPMQ_ZERO32;
        end
      endcase
    end
    // Outbound gate
    st_next.fwd = ROOT_PORT && st_next.gate && outbound_window_req;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign outbound_window_fwd = st_reg.fwd;
endmodule // rpmq_regs

// File: rpmq_regs_asserts.sv
// Port-level checks of the root port queue registers
`timescale 1ns/10ps
module rpmq_regs_asserts #(
  parameter bit ROOT_PORT = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Link, gate and messages
  input wire logic link_up,
  input wire logic outbound_window_req,
  input wire logic outbound_window_fwd,
  input wire logic err_msg_valid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  sequence rd_s(a);
    reg_rd && reg_addr == a;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  fwd_needs_req_a: assert property (outbound_window_fwd |-> $past(outbound_window_req))
    else $error("forward without request");
  link_fall_a: assert property ($fell(link_up) && !reg_wr ##1 !reg_wr |=> !outbound_window_fwd)
    else $error("forward after link fall");
  gate_rw_a: assert property (link_up ##1 link_up && reg_wr && reg_addr == 12'h148
    ##1 reg_rd && reg_addr == 12'h148 && link_up
    |=> reg_rdata[0] == (ROOT_PORT && $past(reg_wdata[0], 2)))
    else $error("gate bit not stored");
  err_ne_a: assert property (err_msg_valid ##1 !reg_wr ##1 rd_s(12'h148)
    |=> reg_rdata[16] == ROOT_PORT)
    else $error("error not-empty low");
  err_ovf_clr_a: assert property (reg_wr && reg_addr == 12'h148 && reg_wdata[17]
    && !err_msg_valid ##1 reg_rd && reg_addr == 12'h148 && !err_msg_valid |=> !reg_rdata[17])
    else $error("error overflow not cleared");
  msi_up_rw_a: assert property (reg_wr && reg_addr == 12'h14C ##1 rd_s(12'h14C)
    |=> reg_rdata == (ROOT_PORT ? $past(reg_wdata, 2) : 32'h0))
    else $error("upper window readback");
  msi_lo_rsv_a: assert property (rd_s(12'h150) |=> reg_rdata[11:0] == 12'h000)
    else $error("lower window low bits set");
  err_fmt_a: assert property (rd_s(12'h154) |=> reg_rdata[31:19] == 13'h0000)
    else $error("error entry upper bits set");
  int_msi_a: assert property (rd_s(12'h158) ##1 reg_rdata[30] |-> reg_rdata[29:27] == 3'h0)
    else $error("message entry line or assert set");
  cover property (outbound_window_fwd);
  cover property (rd_s(12'h148) ##1 reg_rdata[17]);
  cover property (rd_s(12'h158) ##1 reg_rdata[30]);
endmodule // rpmq_regs_asserts

// File: rpmq_endpoint_model.sv
// Endpoint side model sending error, legacy and message-signalled interrupts
`timescale 1ns/10ps
module rpmq_endpoint_model import rpmq_pkg::*; (
  // Clock
  input wire logic mclk,
  // Message outputs
  output logic memwr_valid,
  output rpmq_memwr_t memwr,
  output logic err_msg_valid,
  output rpmq_err_msg_t err_msg,
  output logic intx_msg_valid,
  output logic [15:0] intx_req_id,
  output logic [1:0] intx_line,
  output logic intx_assert
);
  initial begin
    {memwr_valid, err_msg_valid, intx_msg_valid} = 3'h0;
    memwr = '0;
    err_msg = '0;
    {intx_req_id, intx_line, intx_assert} = '0;
  end
  // Fields show inverted values once a message is gone
  task automatic send_err(input rpmq_err_msg_t m, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    err_msg_valid <= 1'b1;
    err_msg <= m;
    @(posedge mclk);
    err_msg_valid <= 1'b0;
    err_msg <= ~m;
  endtask
  task automatic send_intx(input logic [15:0] id, input logic [1:0] ln, input logic a, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    intx_msg_valid <= 1'b1;
    {intx_req_id, intx_line, intx_assert} <= {id, ln, a};
    @(posedge mclk);
    intx_msg_valid <= 1'b0;
    {intx_req_id, intx_line, intx_assert} <= ~{id, ln, a};
  endtask
  task automatic send_msi(input rpmq_memwr_t w, input int gap);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    memwr_valid <= 1'b1;
    memwr <= w;
    @(posedge mclk);
    memwr_valid <= 1'b0;
    memwr <= ~w;
  endtask
endmodule // rpmq_endpoint_model

// File: rpmq_regs_tb.sv
// Self-checking bench of the root port queue registers
`timescale 1ns/10ps
`include "rpmq_consts.svh"
module rpmq_regs_tb import rpmq_pkg::*;;
  localparam int ED = 4;
  localparam int ID = 8;
  logic mclk, rst_b, reg_wr, reg_rd, link_up, outbound_window_req, outbound_window_fwd;
  logic memwr_valid, err_msg_valid, intx_msg_valid, intx_assert, a, ep_fwd;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd, u, l, ep_rdata, ep_rd;
  logic [15:0] intx_req_id, id;
  logic [1:0] intx_line;
  rpmq_memwr_t memwr, w;
  rpmq_err_msg_t err_msg, m;
  logic [31:0] eq[$], iq[$];
  int n_fail, num_checks;
  rpmq_regs #(.ROOT_PORT(1'b1), .ERR_DEPTH(ED), .INT_DEPTH(ID)) i_rpmq_regs (.mclk, .rst_b,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_up, .outbound_window_req,
    .outbound_window_fwd, .memwr_valid, .memwr, .err_msg_valid, .err_msg, .intx_msg_valid,
    .intx_req_id, .intx_line, .intx_assert);
  rpmq_endpoint_model i_rpmq_endpoint_model (.mclk, .memwr_valid, .memwr, .err_msg_valid,
    .err_msg, .intx_msg_valid, .intx_req_id, .intx_line, .intx_assert);
  // Endpoint build fed with the same stimulus
  rpmq_regs #(.ROOT_PORT(1'b0), .ERR_DEPTH(ED), .INT_DEPTH(ID)) i_rpmq_regs_ep (.mclk, .rst_b,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata(ep_rdata), .link_up,
    .outbound_window_req, .outbound_window_fwd(ep_fwd), .memwr_valid, .memwr, .err_msg_valid,
    .err_msg, .intx_msg_valid, .intx_req_id, .intx_line, .intx_assert);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic bus(input logic wr, input logic rq, input logic [11:0] ad, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= wr;
    reg_rd <= rq;
    reg_addr <= ad;
    reg_wdata <= d;
  endtask
  task automatic rdr(input logic [11:0] ad);
    bus(1'b0, 1'b1, ad, 32'h0);
    bus(1'b0, 1'b0, ad, 32'h0);
    #1 rd = reg_rdata;
    ep_rd = ep_rdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  function automatic logic [31:0] ef(input rpmq_err_msg_t x);
    return {13'h0000, 1'b1, x};
  endfunction
  task automatic ipush(input logic [31:0] h, input logic [31:0] p);
    if (iq.size() < 2 * ID) begin
      iq.push_back(h);
      iq.push_back(p);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    stop_test;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_b, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    {link_up, outbound_window_req} = 2'h3;
    n_fail = 0;
    num_checks = 0;
    void'($urandom(52));
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    // Reset values, then an unmapped offset
    for (int i = 0; i < 7; i++) begin
      rdr(12'h148 + 12'(4 * i));
      chk(rd, 32'h0);
    end
    chk({31'h0, outbound_window_fwd}, 32'h0);
    bus(1'b1, 1'b0, 12'h148, 32'h1);
    bus(1'b0, 1'b0, 12'h148, 32'h0);
    @(posedge mclk);
    #1 chk({31'h0, outbound_window_fwd}, 32'h1);
    chk({31'h0, ep_fwd}, 32'h0);
    outbound_window_req <= 1'b0;
    @(posedge mclk);
    #1 chk({31'h0, outbound_window_fwd}, 32'h0);
    outbound_window_req <= 1'b1;
    @(posedge mclk);
    link_up <= 1'b0;
    repeat (3) @(posedge mclk);
    #1 chk({31'h0, outbound_window_fwd}, 32'h0);
    rdr(12'h148);
    chk(rd, 32'h0);
    link_up <= 1'b1;
    u = $urandom;
    l = $urandom;
    bus(1'b1, 1'b0, 12'h14C, u);
    rdr(12'h14C);
    chk(rd, u);
    chk(ep_rd, 32'h0);
    bus(1'b1, 1'b0, 12'h150, l);
    rdr(12'h150);
    chk(rd, l & `RPMQ_MSI_LO_MASK);
    chk(ep_rd, 32'h0);
    // Error queue: every severity, one past full
    for (int i = 0; i <= ED; i++) begin
      m = {i[1:0], 16'($urandom)};
      i_rpmq_endpoint_model.send_err(m, i);
      if (eq.size() < ED) eq.push_back(ef(m));
    end
    rdr(12'h148);
    chk(rd, 32'h00030000);
    chk(ep_rd, 32'h0);
    while (eq.size() > 0) begin
      rdr(12'h154);
      chk(rd, eq[0]);
      rdr(12'h154);
      chk(rd, eq.pop_front());
      bus(1'b1, 1'b0, 12'h154, $urandom);
    end
    rdr(12'h154);
    chk({31'h0, rd[18]}, 32'h0);
    bus(1'b1, 1'b0, 12'h154, 32'h0);
    rdr(12'h148);
    chk(rd, 32'h00020000);
    bus(1'b1, 1'b0, 12'h148, 32'h00020000);
    rdr(12'h148);
    chk(rd, 32'h0);
    // Interrupt queue: hit, miss, all lines, two past full
    for (int i = 0; i < 11; i++) begin
      w = {u, l[31:12], 12'($urandom), 32'($urandom)};
      if (i == 1) w.addr[40] = ~w.addr[40];
      if (i < 2) begin
        i_rpmq_endpoint_model.send_msi(w, i);
        if (i == 0) ipush({5'b11000, w.addr[12:2], w.req_id}, {16'h0, w.data});
      end else begin
        a = 1'($urandom);
        id = 16'($urandom);
        i_rpmq_endpoint_model.send_intx(id, 2'(i - 2), a, 0);
        ipush({2'b10, a, 2'(i - 2), 11'h0, id}, 32'h0);
      end
    end
    rdr(12'h148);
    chk(rd, 32'h000C0000);
    chk(ep_rd, 32'h0);
    for (int k = 0; iq.size() > 0; k++) begin
      rdr(12'h158);
      chk(ep_rd, 32'h0);
      chk(rd, iq.pop_front());
      rdr(12'h15C);
      chk(rd, iq.pop_front());
      bus(1'b1, 1'b0, k[0] ? 12'h15C : 12'h158, $urandom);
    end
    rdr(12'h158);
    chk({31'h0, rd[31]}, 32'h0);
    bus(1'b1, 1'b0, 12'h148, 32'h00080000);
    rdr(12'h148);
    chk(rd, 32'h0);
    stop_test;
  end
endmodule // rpmq_regs_tb
bind rpmq_regs rpmq_regs_asserts #(.ROOT_PORT(ROOT_PORT)) i_rpmq_regs_asserts (.mclk, .rst_b,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .link_up, .outbound_window_req,
  .outbound_window_fwd, .err_msg_valid);
